// ---- rtl/lpm_top.sv ----
// Lane-to-port map and per-port PHY parameter registers of a packet switch
// Assumes straps and config port synchronous to ref_clk; PHY is outside.
`timescale 1ns/1ps
module lpm_top #(
  parameter int LANES = 8,                           // Serial lanes
  parameter int PORTS = 6                            // Ports with PHY registers
) (
  input  wire logic                   ref_clk,       // 50 MHz clock
  input  wire logic                   rst_n,         // Async reset, low
  input  wire lpm_pkg::lpm_mode_t     mode_strap,    // Lane/port mode strap
  input  wire logic [3:0]             upstream_port_select, // Upstream lane select
  input  wire logic                   cfg_wr_en,     // Config write strobe
  input  wire logic                   cfg_rd_en,     // Config read strobe
  input  wire lpm_pkg::lpm_port_t     cfg_port,      // Port addressed
  input  wire logic [7:0]             cfg_addr,      // Register offset
  input  wire logic [31:0]            cfg_wdata,     // Write data
  input  wire logic [LANES-1:0]       rxdet_start,   // Start detect wait, per lane
  output logic [31:0]                 cfg_rdata_q,   // Read data
  output logic                        cfg_rd_valid_q,// Read data valid pulse
  output logic                        strap_taken_q, // Map latched
  output logic                        map_supported_q, // Strap combination valid
  output lpm_pkg::lpm_port_t [LANES-1:0] lane_port_q, // Port of each lane
  output logic [LANES-1:0]            lane_used_q,   // Lane in use
  output logic [LANES-1:0]            lane_upstream_q, // Lane on upstream port
  output logic [LANES-1:0][1:0]       lane_sigdet_q, // Signal-detect threshold
  output logic [LANES-1:0][3:0]       lane_rx_eq_q,  // Receiver equalization
  output logic [LANES-1:0]            lane_half_swing_q, // Half swing selected
  output lpm_pkg::lpm_level_t [LANES-1:0] lane_amp_q, // Amplitude, 25 mV steps
  output lpm_pkg::lpm_level_t [LANES-1:0] lane_deemph_q, // De-emphasis, 6.25 mV steps
  output logic [LANES-1:0]            lane_rxdet_busy_q, // Detect wait running
  output logic [LANES-1:0]            lane_rxdet_sample_q // Sample comparator pulse
);
  import lpm_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (LANES != 8) begin : g_bad_lanes
    $error("lpm_top: lane map serves exactly eight lanes");
  end
  if (PORTS != 6) begin : g_bad_ports
    $error("lpm_top: lane map serves exactly six ports");
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [31:0]            opmode_q [PORTS];
  logic [31:0]            phy1_q   [PORTS];
  logic [31:0]            phy2_q   [PORTS];
  lpm_cap_t               cap_q;
  lpm_mode_t              mode_q;
  logic [3:0]             sel_q;
  lpm_port_t [LANES-1:0]  map_port;
  logic [LANES-1:0]       map_used;
  logic                   map_ok;
  lpm_cnt_t               cnt_q [LANES];
  logic                   port_ok;
  logic [31:0]            status;

  // Decode of the live strap pins
  lpm_lane_map lpm_lane_map_inst (
    .mode   (mode_strap),
    .sel    (upstream_port_select),
    .port_o (map_port),
    .used_o (map_used),
    .ok_o   (map_ok)
  );

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  // First edge after release latches the map; held until next reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_q           <= LPM_CAP_WAIT;
      strap_taken_q   <= 1'b0;
      map_supported_q <= 1'b0;
      mode_q          <= LPM_MODE_505;
      sel_q           <= 4'h0;
      lane_port_q     <= '0;
      lane_used_q     <= '0;
      lane_upstream_q <= '0;
    end else begin
      case (cap_q)
        LPM_CAP_WAIT: begin
          cap_q           <= LPM_CAP_DONE;
          strap_taken_q   <= 1'b1;
          map_supported_q <= map_ok;
          mode_q          <= mode_strap;
          sel_q           <= upstream_port_select;
          lane_port_q     <= map_port;
          lane_used_q     <= map_used;
          for (int n = 0; n < LANES; n++) begin
            lane_upstream_q[n] <= map_used[n] && (map_port[n] == 3'h0);
          end
        end
        LPM_CAP_DONE: cap_q <= LPM_CAP_DONE;
        default:      cap_q <= LPM_CAP_WAIT;
      endcase
    end
  end

  // ****************************************************************
  // Per-port registers
  // ****************************************************************
  assign port_ok = (cfg_port < lpm_port_t'(PORTS));

  // Writes from the EEPROM loader or management master
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < PORTS; p++) begin
        opmode_q[p] <= `LPM_RST_OPMODE;
        phy1_q[p]   <= `LPM_RST_PHY1;
        phy2_q[p]   <= `LPM_RST_PHY2;
      end
    end else if (cfg_wr_en && port_ok) begin
      case (cfg_addr)
        `LPM_OFF_OPMODE: opmode_q[cfg_port] <= cfg_wdata;
        `LPM_OFF_PHY1:   phy1_q[cfg_port]   <= cfg_wdata;
        `LPM_OFF_PHY2:   phy2_q[cfg_port]   <= cfg_wdata;
        default:         ;
      endcase
    end
  end

  // Status word shows the latched map state
  assign status = {24'h00_0000, sel_q, mode_q, map_supported_q, strap_taken_q};

  // Reads answer one cycle later; unmapped reads return zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata_q    <= 32'h0000_0000;
      cfg_rd_valid_q <= 1'b0;
    end else begin
      cfg_rd_valid_q <= cfg_rd_en;
      if (cfg_rd_en) begin
        cfg_rdata_q <= 32'h0000_0000;
        if (cfg_addr == `LPM_OFF_STATUS) begin
          cfg_rdata_q <= status;
        end else if (port_ok) begin
          case (cfg_addr)
            `LPM_OFF_OPMODE: cfg_rdata_q <= opmode_q[cfg_port];
            `LPM_OFF_PHY1:   cfg_rdata_q <= phy1_q[cfg_port];
            `LPM_OFF_PHY2:   cfg_rdata_q <= phy2_q[cfg_port];
            default:         cfg_rdata_q <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // Per-lane PHY controls
  // ****************************************************************
  // Each lane takes the fields of its own port; unused lanes idle at zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lane_sigdet_q     <= '0;
      lane_rx_eq_q      <= '0;
      lane_half_swing_q <= '0;
      lane_amp_q        <= '0;
      lane_deemph_q     <= '0;
    end else begin
      for (int n = 0; n < LANES; n++) begin
        lane_sigdet_q[n]     <= 2'h0;
        lane_rx_eq_q[n]      <= 4'h0;
        lane_half_swing_q[n] <= 1'b0;
        lane_amp_q[n]        <= 6'h00;
        lane_deemph_q[n]     <= 6'h00;
        if (lane_used_q[n]) begin
          lane_sigdet_q[n] <= phy2_q[lane_port_q[n]][`LPM_SIGDET_MSB:`LPM_SIGDET_LSB];
          lane_rx_eq_q[n]  <= phy2_q[lane_port_q[n]][`LPM_EQ_MSB:`LPM_EQ_LSB];
          lane_half_swing_q[n] <= phy2_q[lane_port_q[n]][`LPM_SWING_BIT];
          if (phy2_q[lane_port_q[n]][`LPM_SWING_BIT]) begin
            // Half swing: half amplitude base, no de-emphasis
            lane_amp_q[n] <= lpm_sum(opmode_q[lane_port_q[n]][`LPM_AMPHALF_MSB:`LPM_AMPHALF_LSB],
                                     phy2_q[lane_port_q[n]][`LPM_AMPOFF_MSB:`LPM_AMPOFF_LSB]);
          end else if (phy2_q[lane_port_q[n]][`LPM_DE6DB_BIT]) begin
            // Full swing with -6.0 db bases
            lane_amp_q[n] <= lpm_sum(opmode_q[lane_port_q[n]][`LPM_AMP6P0_MSB:`LPM_AMP6P0_LSB],
                                     phy2_q[lane_port_q[n]][`LPM_AMPOFF_MSB:`LPM_AMPOFF_LSB]);
            lane_deemph_q[n] <= lpm_sum(phy1_q[lane_port_q[n]][`LPM_DE6P0_MSB:`LPM_DE6P0_LSB],
                                        phy2_q[lane_port_q[n]][`LPM_DEOFF_MSB:`LPM_DEOFF_LSB]);
          end else begin
            // Full swing with -3.5 db bases, offset per port
            lane_amp_q[n] <= lpm_sum(opmode_q[lane_port_q[n]][`LPM_AMP3P5_MSB:`LPM_AMP3P5_LSB],
                                     phy2_q[lane_port_q[n]][`LPM_AMPOFF_MSB:`LPM_AMPOFF_LSB]);
            lane_deemph_q[n] <= lpm_sum(phy1_q[lane_port_q[n]][`LPM_DE3P5_MSB:`LPM_DE3P5_LSB],
                                        phy2_q[lane_port_q[n]][`LPM_DEOFF_MSB:`LPM_DEOFF_LSB]);
          end
        end
      end
    end
  end

  // ****************************************************************
  // Receiver-detect wait timers
  // ****************************************************************
  // Start while idle loads the count; sample pulses as it runs out
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int n = 0; n < LANES; n++) begin
        cnt_q[n] <= 12'h000;
      end
      lane_rxdet_busy_q   <= '0;
      lane_rxdet_sample_q <= '0;
    end else begin
      for (int n = 0; n < LANES; n++) begin
        lane_rxdet_sample_q[n] <= (cnt_q[n] == 12'h001);
        if (cnt_q[n] == 12'h000) begin
          if (rxdet_start[n] && lane_used_q[n]) begin
            cnt_q[n] <= lpm_rxdet_cyc(phy2_q[lane_port_q[n]][`LPM_RXDET_MSB:`LPM_RXDET_LSB]);
            lane_rxdet_busy_q[n] <= 1'b1;
          end else begin
            lane_rxdet_busy_q[n] <= 1'b0;
          end
        end else begin
          cnt_q[n] <= cnt_q[n] - 12'h001;
          lane_rxdet_busy_q[n] <= (cnt_q[n] != 12'h001);
        end
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  chk_map_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
    strap_taken_q |=> $stable(lane_port_q) && $stable(lane_used_q) && strap_taken_q)
    else $error("lane map changed after capture");

  chk_rsvd_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (strap_taken_q && mode_q == LPM_MODE_RSVD) |-> !map_supported_q && lane_used_q == 8'h00)
    else $error("reserved mode accepted");

  chk_508_bond: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (strap_taken_q && mode_q == LPM_MODE_508 && sel_q == 4'h0) |->
      lane_used_q == 8'hff && lane_upstream_q == 8'h0f && lane_port_q[7] == 3'h4)
    else $error("508 map wrong");

  chk_505_unused: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (strap_taken_q && mode_q == LPM_MODE_505) |-> lane_used_q[3:1] == 3'h0)
    else $error("505 middle lanes in use");

  chk_606_lane1: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (strap_taken_q && map_supported_q && mode_q == LPM_MODE_606) |->
      lane_used_q[1] && (lane_port_q[1] == ((sel_q == 4'h4) ? 3'h0 : 3'h5)))
    else $error("606 lane 1 port wrong");

  chk_one_upstream: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (strap_taken_q && map_supported_q && mode_q != LPM_MODE_508) |-> $onehot(lane_upstream_q))
    else $error("upstream port not on one lane");

  chk_rxdet_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rxdet_start[4] && lane_used_q[4] && cnt_q[4] == 12'h000 &&
     phy2_q[lane_port_q[4]][`LPM_RXDET_MSB:`LPM_RXDET_LSB] == 3'h0)
      |=> lane_rxdet_busy_q[4] [*8] ##42 !lane_rxdet_sample_q[4] ##1 lane_rxdet_sample_q[4])
    else $error("detect wait not 50 cycles");

  chk_half_nodeemph: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lane_half_swing_q[4] |-> lane_deemph_q[4] == 6'h00)
    else $error("de-emphasis in half swing");

  chk_amp_sum: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (lane_used_q[0] && !phy2_q[lane_port_q[0]][`LPM_SWING_BIT] &&
     !phy2_q[lane_port_q[0]][`LPM_DE6DB_BIT]) |=>
      lane_amp_q[0] == lpm_sum($past(opmode_q[lane_port_q[0]][`LPM_AMP3P5_MSB:`LPM_AMP3P5_LSB]),
                               $past(phy2_q[lane_port_q[0]][`LPM_AMPOFF_MSB:`LPM_AMPOFF_LSB])))
    else $error("amplitude not base plus offset");

  chk_wr_readback: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cfg_wr_en && port_ok && cfg_addr == `LPM_OFF_PHY2) ##1 !cfg_wr_en ##1
    (cfg_rd_en && !cfg_wr_en && cfg_addr == `LPM_OFF_PHY2 && cfg_port == $past(cfg_port, 2)) |=>
      cfg_rd_valid_q && cfg_rdata_q == $past(cfg_wdata, 3))
    else $error("written field not read back");
endmodule

// ---- rtl/lpm_regs.svh ----
// Register offsets, field positions, reset values and timing figures
// Assumes inclusion by the package only; definitions, no logic.
`ifndef LPM_REGS_SVH
`define LPM_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define LPM_OFF_OPMODE   8'h74
`define LPM_OFF_PHY1     8'h78
`define LPM_OFF_PHY2     8'h7c
`define LPM_OFF_STATUS   8'h80

// ****************************************************************
// Field positions
// ****************************************************************
`define LPM_RXDET_LSB    4
`define LPM_RXDET_MSB    6
`define LPM_SIGDET_LSB   20
`define LPM_SIGDET_MSB   21
`define LPM_EQ_LSB       22
`define LPM_EQ_MSB       25
`define LPM_SWING_BIT    30
`define LPM_DE6DB_BIT    31
`define LPM_AMPOFF_LSB   8
`define LPM_AMPOFF_MSB   11
`define LPM_DEOFF_LSB    12
`define LPM_DEOFF_MSB    15
`define LPM_AMP3P5_LSB   16
`define LPM_AMP3P5_MSB   20
`define LPM_AMP6P0_LSB   21
`define LPM_AMP6P0_MSB   25
`define LPM_AMPHALF_LSB  26
`define LPM_AMPHALF_MSB  30
`define LPM_DE3P5_LSB    0
`define LPM_DE3P5_MSB    4
`define LPM_DE6P0_LSB    5
`define LPM_DE6P0_MSB    9

// ****************************************************************
// Reset values
// ****************************************************************
`define LPM_RST_OPMODE   32'h0000_0000
`define LPM_RST_PHY1     32'h0000_0000
`define LPM_RST_PHY2     32'h0190_0020

// ****************************************************************
// Timing
// ****************************************************************
`define LPM_CLK_NS       20
`define LPM_RXDET_T0_NS  1000
`define LPM_RXDET_T1_NS  2000
`define LPM_RXDET_T2_NS  4000
`define LPM_RXDET_T3_NS  5000
`define LPM_RXDET_T4_NS  10000
`define LPM_RXDET_T5_NS  20000
`define LPM_RXDET_T6_NS  40000
`define LPM_RXDET_T7_NS  50000

`endif

// ---- rtl/lpm_pkg.sv ----
// Types and shared helpers of the lane/port map and PHY config block
// Assumes the register header sits beside it on the include path.
package lpm_pkg;
  `include "lpm_regs.svh"

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    LPM_MODE_505,
    LPM_MODE_606,
    LPM_MODE_508,
    LPM_MODE_RSVD
  } lpm_mode_t;

  typedef enum logic {
    LPM_CAP_WAIT,
    LPM_CAP_DONE
  } lpm_cap_t;

  typedef logic [2:0]  lpm_port_t;
  typedef logic [11:0] lpm_cnt_t;
  typedef logic [5:0]  lpm_level_t;

  // Least wait rounded up to whole clock cycles
  function automatic lpm_cnt_t lpm_ns_to_cyc(input int ns);
    int cyc;
    cyc = (ns + `LPM_CLK_NS - 1) / `LPM_CLK_NS;
    if (cyc < 1) cyc = 1;
    return lpm_cnt_t'(cyc);
  endfunction

  // Receiver-detect wait code to cycle count
  function automatic lpm_cnt_t lpm_rxdet_cyc(input logic [2:0] code);
    case (code)
      3'h0:    return lpm_ns_to_cyc(`LPM_RXDET_T0_NS);
      3'h1:    return lpm_ns_to_cyc(`LPM_RXDET_T1_NS);
      3'h2:    return lpm_ns_to_cyc(`LPM_RXDET_T2_NS);
      3'h3:    return lpm_ns_to_cyc(`LPM_RXDET_T3_NS);
      3'h4:    return lpm_ns_to_cyc(`LPM_RXDET_T4_NS);
      3'h5:    return lpm_ns_to_cyc(`LPM_RXDET_T5_NS);
      3'h6:    return lpm_ns_to_cyc(`LPM_RXDET_T6_NS);
      default: return lpm_ns_to_cyc(`LPM_RXDET_T7_NS);
    endcase
  endfunction

  // Base level plus offset step count
  function automatic lpm_level_t lpm_sum(input logic [4:0] base, input logic [3:0] off);
    return lpm_level_t'({1'b0, base} + {2'b00, off});
  endfunction
endpackage

// ---- rtl/lpm_lane_map.sv ----
// Combinational decode of mode strap and upstream select into a lane map
// Assumes settled inputs; the caller latches the result.
`timescale 1ns/1ps
module lpm_lane_map (
  input  wire lpm_pkg::lpm_mode_t       mode,     // Mode strap
  input  wire logic [3:0]               sel,      // Upstream select
  output lpm_pkg::lpm_port_t [7:0]      port_o,   // Port number per lane
  output logic [7:0]                    used_o,   // Lane in use
  output logic                          ok_o      // Combination supported
);
  import lpm_pkg::*;

  // ****************************************************************
  // Map decode
  // ****************************************************************
  // Start from the plain map, then swap the chosen lane with lane 0
  always_comb begin
    port_o = '0;
    used_o = 8'h00;
    ok_o   = 1'b0;
    port_o[4] = 3'h1;
    port_o[5] = 3'h2;
    port_o[6] = 3'h3;
    port_o[7] = 3'h4;
    case (mode)
      LPM_MODE_508: begin
        ok_o   = (sel == 4'h0);
        used_o = 8'hff;
      end
      LPM_MODE_505, LPM_MODE_606: begin
        used_o = 8'hf1;
        if (mode == LPM_MODE_606) begin
          used_o[1] = 1'b1;
          port_o[1] = 3'h5;
        end
        ok_o = 1'b1;
        case (sel)
          4'h0: ok_o = 1'b1;
          4'h1: begin
            port_o[4] = 3'h0;
            port_o[0] = 3'h1;
          end
          4'h5: begin
            port_o[5] = 3'h0;
            port_o[0] = 3'h2;
          end
          4'h7: begin
            port_o[6] = 3'h0;
            port_o[0] = 3'h3;
          end
          4'h9: begin
            port_o[7] = 3'h0;
            port_o[0] = 3'h4;
          end
          4'h4: begin
            ok_o = (mode == LPM_MODE_606);
            port_o[1] = 3'h0;
            port_o[0] = 3'h5;
          end
          default: ok_o = 1'b0;
        endcase
      end
      default: ok_o = 1'b0;
    endcase
    if (!ok_o) begin
      port_o = '0;
      used_o = 8'h00;
    end
  end
endmodule

// ---- testbench/lpm_cfg_master.sv ----
// Config master model: the management side that loads PHY fields
// Assumes the config port contract: one-cycle strobes, read data a cycle later.
`timescale 1ns/1ps
module lpm_cfg_master (
  input  wire logic          ref_clk,        // Clock
  input  wire logic [31:0]   cfg_rdata_q,    // Read data
  input  wire logic          cfg_rd_valid_q, // Read valid
  output lpm_pkg::lpm_port_t cfg_port,       // Port addressed
  output logic               cfg_wr_en,      // Write strobe
  output logic               cfg_rd_en,      // Read strobe
  output logic [7:0]         cfg_addr,       // Register offset
  output logic [31:0]        cfg_wdata       // Write data
);
  import lpm_pkg::*;
  // ****************************************************************
  // Idle bus at time zero
  // ****************************************************************
  initial begin
    cfg_wr_en = 1'b0;
    cfg_rd_en = 1'b0;
    cfg_port  = 3'h0;
    cfg_addr  = 8'h00;
    cfg_wdata = 32'h0000_0000;
  end
  // One write per port register; data scrambled once taken
  task automatic wr(input lpm_port_t p, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cfg_wr_en <= 1'b1;
    cfg_port  <= p;
    cfg_addr  <= a;
    cfg_wdata <= d;
    @(posedge ref_clk);
    cfg_wr_en <= 1'b0;
    cfg_wdata <= ~d;
  endtask
  // One read; data and valid taken while the valid pulse stands
  task automatic rd(input lpm_port_t p, input logic [7:0] a, output logic [31:0] d, output logic ok);
    @(posedge ref_clk);
    cfg_rd_en <= 1'b1;
    cfg_port  <= p;
    cfg_addr  <= a;
    @(posedge ref_clk);
    cfg_rd_en <= 1'b0;
    cfg_addr  <= ~a;
    #1;
    ok = cfg_rd_valid_q;
    d  = cfg_rdata_q;
  endtask
endmodule

// ---- testbench/test_lane_port_map_phy_config.sv ----
// Testbench: strap decode per reset, register access, lane fields, detect wait
// Assumes lpm_top and the config master model are compiled before it.
`timescale 1ns/1ps
module test_lane_port_map_phy_config;
  import lpm_pkg::*;
  logic ref_clk, rst_n, cfg_wr_en, cfg_rd_en, cfg_rd_valid_q, strap_taken_q, map_supported_q, ok;
  logic [3:0] upstream_port_select;
  logic [7:0] cfg_addr, rxdet_start, lane_used_q, lane_upstream_q, lane_half_swing_q, busy_q, smp_q, eu, ep;
  logic [31:0] cfg_wdata, cfg_rdata_q, rv;
  logic [23:0] epv;
  lpm_mode_t mode_strap;
  lpm_port_t cfg_port;
  lpm_port_t [7:0] lane_port_q;
  logic [7:0][1:0] lane_sigdet_q;
  logic [7:0][3:0] lane_rx_eq_q;
  lpm_level_t [7:0] lane_amp_q, lane_deemph_q;
  int err_count, total_checks;
  // Strap cases: mode, select, port per lane (f = unused)
  logic [1:0] mt[10] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h3, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2};
  logic [3:0] st[10] = '{4'h0, 4'h1, 4'h4, 4'h9, 4'h0, 4'h4, 4'h5, 4'h7, 4'h1, 4'h0};
  logic [31:0] pm[10] = '{32'h4321fff0, 32'h4320fff1, 32'h4321ff05, 32'h0321ff54,
                          32'hffffffff, 32'hffffffff, 32'h4301fff2, 32'h4021ff53,
                          32'hffffffff, 32'h43210000};
  // Port 1 PHY words with expected amp, de-emphasis, half swing
  logic [31:0] pv[3] = '{32'h01902320, 32'h81902320, 32'h43b02300};
  logic [7:0] xa[3] = '{8'h13, 8'h0f, 8'h0b};
  logic [7:0] xd[3] = '{8'h0c, 8'h08, 8'h00};
  lpm_top lpm_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .mode_strap(mode_strap),
    .upstream_port_select(upstream_port_select), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
    .cfg_port(cfg_port), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .rxdet_start(rxdet_start),
    .cfg_rdata_q(cfg_rdata_q), .cfg_rd_valid_q(cfg_rd_valid_q), .strap_taken_q(strap_taken_q),
    .map_supported_q(map_supported_q), .lane_port_q(lane_port_q), .lane_used_q(lane_used_q),
    .lane_upstream_q(lane_upstream_q), .lane_sigdet_q(lane_sigdet_q), .lane_rx_eq_q(lane_rx_eq_q),
    .lane_half_swing_q(lane_half_swing_q), .lane_amp_q(lane_amp_q), .lane_deemph_q(lane_deemph_q),
    .lane_rxdet_busy_q(busy_q), .lane_rxdet_sample_q(smp_q));
  lpm_cfg_master lpm_cfg_master_inst (.ref_clk(ref_clk), .cfg_rdata_q(cfg_rdata_q),
    .cfg_rd_valid_q(cfg_rd_valid_q), .cfg_port(cfg_port), .cfg_wr_en(cfg_wr_en),
    .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Reset two cycles with straps set; map latches on the first edge after
  task automatic boot(input logic [1:0] m, input logic [3:0] s);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    mode_strap <= lpm_mode_t'(m);
    upstream_port_select <= s;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  // Count cycles from the taken start edge to the sample pulse
  task automatic det(input int l, input int n);
    int c;
    @(posedge ref_clk);
    rxdet_start[l] <= 1'b1;
    @(posedge ref_clk);
    rxdet_start[l] <= 1'b0;
    for (c = 1; c < 3000; c++) begin
      @(posedge ref_clk);
      #1;
      if (c == 1) chk(busy_q[l], 1'b1);
      if (smp_q[l] === 1'b1) break;
    end
    chk(c, n);
    chk({busy_q[l], smp_q[l]}, 2'b01);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #400000;
    err_count++;
    tally_and_finish();
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    mode_strap = LPM_MODE_505;
    upstream_port_select = 4'h0;
    rxdet_start = 8'h00;
    for (int i = 0; i < 10; i++) begin
      boot(mt[i], st[i]);
      for (int l = 0; l < 8; l++) begin
        eu[l] = pm[i][4*l+:4] != 4'hf;
        ep[l] = pm[i][4*l+:4] == 4'h0;
        epv[3*l+:3] = eu[l] ? pm[i][4*l+:3] : 3'h0;
      end
      chk(lane_port_q, epv);
      chk(lane_used_q, eu);
      chk(lane_upstream_q, ep);
      chk({strap_taken_q, map_supported_q}, {1'b1, pm[i] != 32'hffffffff});
      mode_strap <= lpm_mode_t'(~mt[i]);
      upstream_port_select <= ~st[i];
      repeat (3) @(posedge ref_clk);
      chk(lane_port_q, epv);
    end
    $display("map test done");
    lpm_cfg_master_inst.rd(3'h0, 8'h7c, rv, ok);
    chk({ok, rv}, {1'b1, 32'h01900020});
    lpm_cfg_master_inst.rd(3'h6, 8'h7c, rv, ok);
    chk(rv, 32'h0);
    lpm_cfg_master_inst.wr(3'h1, 8'h84, 32'hdead_beef);
    lpm_cfg_master_inst.rd(3'h1, 8'h84, rv, ok);
    chk(rv, 32'h0);
    chk({lane_sigdet_q[0], lane_rx_eq_q[0], lane_half_swing_q[0]}, 7'h2c);
    det(0, 200);
    lpm_cfg_master_inst.wr(3'h1, 8'h74, 32'h2190_0000);
    lpm_cfg_master_inst.wr(3'h1, 8'h78, 32'h0000_00ca);
    for (int j = 0; j < 3; j++) begin
      lpm_cfg_master_inst.wr(3'h1, 8'h7c, pv[j]);
      lpm_cfg_master_inst.rd(3'h1, 8'h7c, rv, ok);
      chk(rv, pv[j]);
      chk({lane_amp_q[4], lane_deemph_q[4]}, {xa[j][5:0], xd[j][5:0]});
      chk({lane_half_swing_q[4], lane_amp_q[0], lane_deemph_q[0]}, {j == 2, 12'h000});
    end
    chk({lane_sigdet_q[4], lane_rx_eq_q[4]}, 6'h3e);
    det(4, 50);
    $display("register and lane field test done");
    tally_and_finish();
  end
endmodule
